// File: logic/dram_term_defs.svh
// Purpose: Constants for the termination and power-down block.
// Assumes: Core clock of 25 MHz (40 ns period).
// Notes: Offsets, field positions, reset values and timing counts.
`ifndef DRAM_TERM_DEFS_SVH
`define DRAM_TERM_DEFS_SVH
`define CORE_CLK_PERIOD_NS 40
`define TERM_MODE_REG_ADDR 8'h0b
`define TERM_MODE_RESET 8'h00
`define STRENGTH_LSB 0
`define STRENGTH_MSB 1
`define PD_TERM_BIT 2
`define TERM_DISABLE_WINDOW_NS 120
`define TERM_ENABLE_WINDOW_NS 120
`define TERM_DISABLE_CYCLES ((`TERM_DISABLE_WINDOW_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define TERM_ENABLE_CYCLES ((`TERM_ENABLE_WINDOW_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define SETTLE_NOPS 2
`define EXIT_LATENCY_NS 80
`define EXIT_LATENCY_CYCLES ((`EXIT_LATENCY_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define READ_BUSY_CYCLES 8
`endif

// File: logic/dram_term_pkg.sv
// Purpose: Types for the termination and power-down block.
// Assumes: Nothing beyond the header of constants.
// Notes: One-hot state codes are written out.
package dram_term_pkg;
  typedef enum logic [4:0] {
    ST_ACTIVE = 5'h01,
    ST_POWERDOWN = 5'h02,
    ST_SELF_REFRESH = 5'h04,
    ST_DEEP_PD = 5'h08,
    ST_EXITING = 5'h10
  } power_state_e;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_READ = 3'h1,
    CMD_MODE_READ = 3'h2,
    CMD_MODE_WRITE = 3'h3,
    CMD_SELF_REFRESH = 3'h4,
    CMD_DEEP_PD = 3'h5,
    CMD_OTHER = 3'h6
  } cmd_e;
endpackage

// File: logic/input_sync.sv
// Purpose: Two-flop synchroniser for a bus of pin levels.
// Assumes: Inputs are asynchronous to core_clk_in.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk_in, // Core clock.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] async_in, // Raw pin levels.
  output logic [WIDTH-1:0] sync_out // Synchronised levels.
);
  logic [WIDTH-1:0] stage1;

  // Both stages clear on reset and then follow the pins.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// File: logic/window_timer.sv
// Purpose: Down counter that measures a window of cycles.
// Assumes: Load and enable are on the core clock.
// Notes: Done is high while the count stands at zero and no load is requested.
`timescale 1ns/1ps
module window_timer #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk_in, // Core clock.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic clk_en_in, // Clock enable.
  input wire logic load_in, // Start a new window.
  input wire logic [WIDTH-1:0] count_in, // Window length in cycles.
  output logic done_out // Window expired.
);
  logic [WIDTH-1:0] count;

  // Load takes priority; otherwise count down to zero.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      count <= '0;
    end else if (clk_en_in) begin
      if (load_in) begin
        count <= count_in;
      end else if (count != '0) begin
        count <= count - 1'b1;
      end
    end
  end

  assign done_out = (count == '0) && !load_in;
endmodule

// File: logic/dram_term_ctrl.sv
// Purpose: Termination control and clock-gate power-down of a memory device.
// Assumes: Command decode is done upstream; gate and select pins arrive raw.
// Notes: Termination pin path is combinational; register and state gates are registered.
`timescale 1ns/1ps
`include "dram_term_defs.svh"

module dram_term_ctrl #(
  parameter int READ_BUSY = `READ_BUSY_CYCLES
) (
  input wire logic core_clk_in, // Core clock, 25 MHz.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic clk_en_in, // Freezes all state except the pin synchroniser while low.
  input wire logic link_clk_in, // Command clock from the controller.
  input wire logic gate_in, // Clock-enable pin from the controller.
  input wire logic chip_select_n_in, // Chip-select pin, active low.
  input wire logic die_termination_enable_in, // Asynchronous termination pin.
  input wire logic [2:0] cmd_in, // Decoded command, one cycle pulse.
  input wire logic [7:0] mode_addr_in, // Mode register address.
  input wire logic [7:0] mode_wdata_in, // Mode register write data.
  input wire logic read_done_in, // Read burst finished.
  input wire logic ca_training_in, // Command-address training active.
  input wire logic write_level_in, // Write leveling active.
  input wire logic sr_exit_in, // Self-refresh exit registered.
  output logic [7:0] mode_rdata_out, // Mode register read data.
  output logic [1:0] termination_resistance_out, // Selected resistance code.
  output logic dq_term_gate_out, // Data-line termination permitted.
  output logic dqs_term_gate_out, // Strobe-pair termination permitted.
  output logic dq_term_out, // Data-line termination switch.
  output logic dqs_term_out, // Strobe-pair termination switch.
  output logic receivers_on_out, // Input receivers active.
  output logic refresh_allowed_out, // Internal refresh permitted.
  output logic cmd_ready_out, // Valid command accepted.
  output logic [4:0] power_state_out // Current power state.
);
  logic [7:0] termination_mode_reg; // Termination mode register.
  dram_term_pkg::power_state_e state; // Current power state.
  logic [2:0] sync_pins; // Synchronised link clock, gate and select.
  logic link_clk_s; // Link clock in the core domain.
  logic gate_s; // Gate pin in the core domain.
  logic cs_n_s; // Select pin in the core domain, active low.
  logic link_clk_d; // Link clock one core cycle later.
  logic link_rise; // Rising link edge seen this cycle.
  logic reading; // A read or mode read is in progress.
  logic [1:0] settle_cnt; // Link edges counted since the gate fell.
  logic disable_load; // Starts the termination disable window.
  logic enable_load; // Starts the termination enable window.
  logic disable_done; // Disable window has run out.
  logic enable_done; // Enable window has run out.
  logic exit_load; // Starts the exit latency.
  logic exit_done; // Exit latency has run out.
  logic term_allowed; // Termination permitted this cycle.
  logic gated_enable; // Termination pin as seen by the switches.
  logic pd_keep; // Termination keeps running in power-down.
  logic [1:0] strength; // Termination strength field.

  // Refuse a read-busy count that the masking logic could not serve.
  if (READ_BUSY < 1) begin : g_read_busy_check
    $error("READ_BUSY must be at least one");
  end

  // Power-down entry: gate registered low with select high at a link edge.
  function automatic logic pd_entry_seen(input logic rise, input logic gate, input logic cs_n);
    pd_entry_seen = rise && !gate && cs_n;
  endfunction

  // Power-down exit: gate registered high with select high at a link edge.
  function automatic logic pd_exit_seen(input logic rise, input logic gate, input logic cs_n);
    pd_exit_seen = rise && gate && cs_n;
  endfunction

  // Reads and mode reads both mask the termination pin.
  function automatic logic is_read(input logic [2:0] cmd);
    is_read = (cmd == dram_term_pkg::CMD_READ) || (cmd == dram_term_pkg::CMD_MODE_READ);
  endfunction

  // Bring the link clock and command pins into the core domain.
  // Gate and select pass the same two flops as the link clock, so they keep their
  // relation to the link edge that registers them.
  input_sync #(.WIDTH(3)) u_sync (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .async_in({link_clk_in, gate_in, chip_select_n_in}),
    .sync_out(sync_pins)
  );
  assign {link_clk_s, gate_s, cs_n_s} = sync_pins;

  // Registered events happen at rising edges of the link clock.
  // The delayed copy resets low like the synchronised clock, so no false edge follows reset.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      link_clk_d <= 1'b0;
    end else if (clk_en_in) begin
      link_clk_d <= link_clk_s;
    end
  end
  assign link_rise = link_clk_s && !link_clk_d;

  // Mode register write and read-back of the termination register.
  // Writes are taken only in the active state; other addresses read back as zero.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      termination_mode_reg <= `TERM_MODE_RESET;
      mode_rdata_out <= 8'h00;
    end else if (clk_en_in && state == dram_term_pkg::ST_ACTIVE) begin
      if (cmd_in == dram_term_pkg::CMD_MODE_WRITE && mode_addr_in == `TERM_MODE_REG_ADDR) begin
        termination_mode_reg <= mode_wdata_in;
      end
      if (cmd_in == dram_term_pkg::CMD_MODE_READ) begin
        mode_rdata_out <= (mode_addr_in == `TERM_MODE_REG_ADDR) ? termination_mode_reg : 8'h00;
      end
    end
  end

  // A zero strength field switches termination off entirely.
  assign strength = termination_mode_reg[`STRENGTH_MSB:`STRENGTH_LSB];

  // Read activity masks the pin until the burst is done.
  // A new read in the same cycle as read_done wins, so the mask is never dropped early.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reading <= 1'b0;
    end else if (clk_en_in) begin
      if (is_read(cmd_in)) begin
        reading <= 1'b1;
      end else if (read_done_in) begin
        reading <= 1'b0;
      end
    end
  end

  // Power state machine driven by gate and select at link edges.
  // Deep power-down is left only through reset, since leaving it needs a full
  // re-initialisation that lies outside this block.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state <= dram_term_pkg::ST_ACTIVE;
    end else if (clk_en_in) begin
      case (state)
        dram_term_pkg::ST_ACTIVE: begin
          if (cmd_in == dram_term_pkg::CMD_SELF_REFRESH) begin
            state <= dram_term_pkg::ST_SELF_REFRESH;
          end else if (cmd_in == dram_term_pkg::CMD_DEEP_PD) begin
            state <= dram_term_pkg::ST_DEEP_PD;
          end else if (pd_entry_seen(link_rise, gate_s, cs_n_s)) begin
            state <= dram_term_pkg::ST_POWERDOWN;
          end
        end
        dram_term_pkg::ST_POWERDOWN: begin
          if (pd_exit_seen(link_rise, gate_s, cs_n_s)) begin
            state <= dram_term_pkg::ST_EXITING;
          end
        end
        dram_term_pkg::ST_SELF_REFRESH: begin
          if (sr_exit_in) begin
            state <= dram_term_pkg::ST_EXITING;
          end
        end
        dram_term_pkg::ST_DEEP_PD: begin
          state <= dram_term_pkg::ST_DEEP_PD;
        end
        dram_term_pkg::ST_EXITING: begin
          if (exit_done) begin
            state <= dram_term_pkg::ST_ACTIVE;
          end
        end
        default: begin
          state <= dram_term_pkg::ST_ACTIVE;
        end
      endcase
    end
  end

  // Exit latency starts on a registered power-down or self-refresh exit.
  assign exit_load = clk_en_in && state != dram_term_pkg::ST_EXITING &&
    ((state == dram_term_pkg::ST_POWERDOWN && pd_exit_seen(link_rise, gate_s, cs_n_s)) ||
     (state == dram_term_pkg::ST_SELF_REFRESH && sr_exit_in));

  // Exit latency before commands are accepted again.
  // The state machine waits in the exiting state until this count runs out.
  window_timer #(.WIDTH(4)) u_exit (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .load_in(exit_load),
    .count_in(4'(`EXIT_LATENCY_CYCLES)),
    .done_out(exit_done)
  );

  // Settle period: receivers switch off after two link cycles of gate low.
  // Keeping them on meanwhile lets the two no-operations still be seen.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      settle_cnt <= 2'h0;
      receivers_on_out <= 1'b1;
    end else if (clk_en_in) begin
      if (state == dram_term_pkg::ST_ACTIVE || state == dram_term_pkg::ST_EXITING) begin
        settle_cnt <= 2'h0;
        receivers_on_out <= 1'b1;
      end else if (link_rise && settle_cnt != 2'(`SETTLE_NOPS)) begin
        settle_cnt <= settle_cnt + 2'h1;
      end else if (settle_cnt == 2'(`SETTLE_NOPS)) begin
        receivers_on_out <= 1'b0;
      end
    end
  end

  // Disable and enable windows for the termination gate.
  // Every entry into a low-power state starts the disable window once.
  assign disable_load = clk_en_in && state == dram_term_pkg::ST_ACTIVE &&
    (cmd_in == dram_term_pkg::CMD_SELF_REFRESH || cmd_in == dram_term_pkg::CMD_DEEP_PD ||
     pd_entry_seen(link_rise, gate_s, cs_n_s));
  assign enable_load = exit_load;

  // Disable window: counts from entry to the point where the gates drop.
  window_timer #(.WIDTH(4)) u_dis (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .load_in(disable_load),
    .count_in(4'(`TERM_DISABLE_CYCLES)),
    .done_out(disable_done)
  );

  // Enable window: counts from exit to the point where the pin regains control.
  window_timer #(.WIDTH(4)) u_en (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .load_in(enable_load),
    .count_in(4'(`TERM_ENABLE_CYCLES)),
    .done_out(enable_done)
  );

  // The power-down bit only matters while the strength field is nonzero.
  assign pd_keep = termination_mode_reg[`PD_TERM_BIT];

  // Termination permission from register and power state.
  // Training overrides every state, so it is applied last.
  always_comb begin
    term_allowed = (strength != 2'b00);
    case (state)
      dram_term_pkg::ST_ACTIVE: term_allowed = term_allowed && !reading;
      dram_term_pkg::ST_POWERDOWN: term_allowed = term_allowed && (pd_keep || !disable_done);
      dram_term_pkg::ST_SELF_REFRESH: term_allowed = term_allowed && !disable_done;
      dram_term_pkg::ST_DEEP_PD: term_allowed = term_allowed && !disable_done;
      dram_term_pkg::ST_EXITING: term_allowed = term_allowed && enable_done && !reading;
      default: term_allowed = 1'b0;
    endcase
    if (ca_training_in) begin
      term_allowed = 1'b0;
    end
  end

  // Registered gates; the pin itself acts without a clock sample.
  // Write leveling keeps data-line termination off while the strobes follow the pin.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      dq_term_gate_out <= 1'b0;
      dqs_term_gate_out <= 1'b0;
      termination_resistance_out <= 2'b00;
    end else if (clk_en_in) begin
      dq_term_gate_out <= term_allowed && !write_level_in;
      dqs_term_gate_out <= term_allowed;
      termination_resistance_out <= strength;
    end
  end

  // Switch outputs: pin asynchronously ANDed with the registered gates.
  // These two outputs skip a flop on purpose: the pin must reach the switches
  // without a clock sample, so only the permissions are registered.
  assign gated_enable = die_termination_enable_in;
  assign dq_term_out = gated_enable && dq_term_gate_out;
  assign dqs_term_out = gated_enable && dqs_term_gate_out;

  // Status: refresh and command readiness follow the power state.
  // Self-refresh keeps its own refresh running; only clock-gate power-down bars it.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      refresh_allowed_out <= 1'b1;
      cmd_ready_out <= 1'b1;
      power_state_out <= 5'h01;
    end else if (clk_en_in) begin
      refresh_allowed_out <= (state != dram_term_pkg::ST_POWERDOWN);
      cmd_ready_out <= (state == dram_term_pkg::ST_ACTIVE);
      power_state_out <= state;
    end
  end
endmodule

// File: bench/dram_term_ctrl_monitor.sv
// Purpose: Port assertions for the termination and power-down block.
// Assumes: Link clock period of eight core cycles.
// Notes: Bound to dram_term_ctrl below.
`timescale 1ns/1ps
module dram_term_ctrl_monitor (
  input wire logic core_clk_in, // Clock.
  input wire logic reset_in, // Reset.
  input wire logic die_termination_enable_in, // Pin.
  input wire logic [2:0] cmd_in, // Command.
  input wire logic ca_training_in, // Training.
  input wire logic [1:0] termination_resistance_out, // Strength.
  input wire logic dq_term_gate_out, // Data gate.
  input wire logic dqs_term_gate_out, // Strobe gate.
  input wire logic dq_term_out, // Data switch.
  input wire logic dqs_term_out, // Strobe switch.
  input wire logic receivers_on_out, // Receivers.
  input wire logic [4:0] power_state_out // State.
);
  // All checks use the core clock and pause during reset.
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  wire logic gates_off = !dq_term_gate_out && !dqs_term_gate_out;
  pin_switch_a: assert property (
    dq_term_out == (die_termination_enable_in && dq_term_gate_out) &&
    dqs_term_out == (die_termination_enable_in && dqs_term_gate_out)) else $error("switch not pin and gate");
  zero_strength_a: assert property (
    termination_resistance_out == 2'h0 && $past(termination_resistance_out) == 2'h0 |-> gates_off)
    else $error("termination on with zero strength");
  training_off_a: assert property (ca_training_in [*2] |-> gates_off) else $error("termination on in training");
  read_mask_a: assert property (
    cmd_in == 3'h1 || cmd_in == 3'h2 |-> ##[1:2] gates_off) else $error("termination on during read");
  sref_off_a: assert property (
    $rose(power_state_out == 5'h04) |-> ##[0:4] gates_off) else $error("self-refresh left termination on");
  dpd_stay_a: assert property (
    $past(power_state_out, 4) == 5'h08 |-> power_state_out == 5'h08 && gates_off) else $error("deep sleep broken");
  settle_a: assert property (
    $rose(power_state_out == 5'h02) |-> receivers_on_out [*8] ##[1:40] !receivers_on_out)
    else $error("receivers off at wrong time");
  exit_latency_a: assert property (
    $rose(power_state_out == 5'h10) |-> (power_state_out == 5'h10) [*3] ##1 power_state_out == 5'h01)
    else $error("exit latency wrong");
endmodule
bind dram_term_ctrl dram_term_ctrl_monitor dram_term_ctrl_monitor_inst (.core_clk_in, .reset_in,
  .die_termination_enable_in, .cmd_in, .ca_training_in, .termination_resistance_out, .dq_term_gate_out,
  .dqs_term_gate_out, .dq_term_out, .dqs_term_out, .receivers_on_out, .power_state_out);

// File: bench/mem_ctrl_model.sv
// Purpose: Controller model for link clock, gate, select and termination pin.
// Assumes: Link period of 320 ns.
// Notes: Gate changes on a falling link edge, half a period before it is registered.
`timescale 1ns/1ps
module mem_ctrl_model #(
  parameter int MIN_PULSE = 3
) (
  output logic link_clk_out, // Link clock.
  output logic gate_out, // Gate pin.
  output logic chip_select_n_out, // Select, active low.
  output logic die_termination_enable_out // Termination pin.
);
  // Idle with gate high and no select; the link clock runs free.
  initial begin
    gate_out = 1'b1;
    chip_select_n_out = 1'b1;
    die_termination_enable_out = 1'b0;
    link_clk_out = 1'b0;
    forever #160 link_clk_out = ~link_clk_out;
  end
  // Drops the gate on a falling link edge so the next rising edge registers it
  // cleanly, then sends no-operations for the settle and pulse time.
  task automatic enter_pd();
    @(negedge link_clk_out);
    gate_out = 1'b0;
    repeat (MIN_PULSE) @(posedge link_clk_out);
  endtask
  // Raises the gate with select high and holds it.
  task automatic exit_pd();
    @(negedge link_clk_out);
    gate_out = 1'b1;
    repeat (MIN_PULSE) @(posedge link_clk_out);
  endtask
  // Sets the termination pin level.
  task automatic set_pin(input logic v);
    die_termination_enable_out = v;
  endtask
endmodule

// File: bench/dram_term_ctrl_tb.sv
// Purpose: Self-checking bench for the termination and power-down block.
// Assumes: 25 MHz core clock, controller model on the link side.
// Notes: Inputs change 2 ns after the core clock rises.
`timescale 1ns/1ps
module dram_term_ctrl_tb;
  logic core_clk_in, reset_in, clk_en_in, read_done_in, ca_training_in, write_level_in, sr_exit_in;
  logic link_clk, gate, cs_n, pin, dq_term_gate_out, dqs_term_gate_out, dq_term_out, dqs_term_out;
  logic receivers_on_out, refresh_allowed_out, cmd_ready_out;
  logic [2:0] cmd_in;
  logic [7:0] mode_addr_in, mode_wdata_in, mode_rdata_out;
  logic [1:0] termination_resistance_out;
  logic [4:0] power_state_out;
  int err_count = 0;
  int n_compared = 0;
  mem_ctrl_model mem_ctrl_model_inst (.link_clk_out(link_clk), .gate_out(gate), .chip_select_n_out(cs_n),
    .die_termination_enable_out(pin));
  dram_term_ctrl dram_term_ctrl_inst (.core_clk_in, .reset_in, .clk_en_in, .link_clk_in(link_clk), .gate_in(gate),
    .chip_select_n_in(cs_n), .die_termination_enable_in(pin), .cmd_in, .mode_addr_in, .mode_wdata_in,
    .read_done_in, .ca_training_in, .write_level_in, .sr_exit_in, .mode_rdata_out, .termination_resistance_out,
    .dq_term_gate_out, .dqs_term_gate_out, .dq_term_out, .dqs_term_out, .receivers_on_out, .refresh_allowed_out,
    .cmd_ready_out, .power_state_out);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #2;
  endtask
  task automatic pulse_cmd(input logic [2:0] c);
    cmd_in = c;
    tick(1);
    cmd_in = 3'h0;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    mode_addr_in = a;
    mode_wdata_in = d;
    pulse_cmd(3'h3);
    tick(3);
  endtask
  // Mode read also masks termination, so the read is closed afterwards.
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    mode_addr_in = a;
    pulse_cmd(3'h2);
    tick(1);
    check(mode_rdata_out, exp);
    read_done_in = 1'b1;
    tick(1);
    read_done_in = 1'b0;
    tick(2);
  endtask
  task automatic wait_state(input logic [4:0] st);
    for (int i = 0; i < 60 && power_state_out !== st; i++)
      tick(1);
  endtask
  task automatic t_strength();
    for (int s = 0; s < 4; s++) begin
      reg_wr(8'h0b, 8'(s));
      check(termination_resistance_out, 8'(s));
      mem_ctrl_model_inst.set_pin(1'b1);
      #1 check({dqs_term_out, dq_term_out}, (s != 0) ? 8'h03 : 8'h00);
      mem_ctrl_model_inst.set_pin(1'b0);
      #1 check({dqs_term_out, dq_term_out}, 8'h00);
      tick(1);
    end
    reg_wr(8'h05, 8'h07);
    reg_rd(8'h05, 8'h00);
    reg_rd(8'h0b, 8'h03);
    // A write while the clock enable is low must leave the register untouched.
    clk_en_in = 1'b0;
    reg_wr(8'h0b, 8'h06);
    clk_en_in = 1'b1;
    reg_rd(8'h0b, 8'h03);
    // Zero strength turns termination off even with the power-down bit set.
    reg_wr(8'h0b, 8'h04);
    mem_ctrl_model_inst.set_pin(1'b1);
    #1 check({dqs_term_out, dq_term_out, termination_resistance_out}, 8'h00);
  endtask
  task automatic t_read_train();
    reg_wr(8'h0b, 8'h01);
    mem_ctrl_model_inst.set_pin(1'b1);
    for (int c = 1; c < 3; c++) begin
      pulse_cmd(3'(c));
      tick(1);
      check({dqs_term_out, dq_term_out}, 8'h00);
      read_done_in = 1'b1;
      tick(1);
      read_done_in = 1'b0;
      tick(3);
      check({dqs_term_out, dq_term_out}, 8'h03);
    end
    ca_training_in = 1'b1;
    tick(2);
    check({dqs_term_out, dq_term_out}, 8'h00);
    ca_training_in = 1'b0;
    write_level_in = 1'b1;
    tick(3);
    check({dqs_term_out, dq_term_out}, 8'h02);
    mem_ctrl_model_inst.set_pin(1'b0);
    #1 check({dqs_term_out, dq_term_out}, 8'h00);
    mem_ctrl_model_inst.set_pin(1'b1);
    write_level_in = 1'b0;
    tick(3);
  endtask
  task automatic t_pd(input logic b);
    reg_wr(8'h0b, {5'h00, b, 2'h2});
    mem_ctrl_model_inst.enter_pd();
    wait_state(5'h02);
    check(power_state_out, 8'h02);
    tick(4);
    check({dqs_term_out, dq_term_out, refresh_allowed_out}, b ? 8'h06 : 8'h00);
    tick(20);
    check(receivers_on_out, 8'h00);
    mem_ctrl_model_inst.exit_pd();
    wait_state(5'h01);
    tick(4);
    check({dqs_term_out, dq_term_out, cmd_ready_out}, 8'h07);
  endtask
  task automatic t_sleep();
    pulse_cmd(3'h4);
    tick(4);
    check({power_state_out, dq_term_out}, 8'h08);
    sr_exit_in = 1'b1;
    tick(1);
    sr_exit_in = 1'b0;
    wait_state(5'h01);
    tick(4);
    check({dqs_term_out, dq_term_out}, 8'h03);
    pulse_cmd(3'h5);
    tick(30);
    check({power_state_out, dqs_term_out}, 8'h10);
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  initial begin
    reset_in = 1'b1;
    clk_en_in = 1'b1;
    cmd_in = 3'h0;
    mode_addr_in = 8'h00;
    mode_wdata_in = 8'h00;
    read_done_in = 1'b0;
    ca_training_in = 1'b0;
    write_level_in = 1'b0;
    sr_exit_in = 1'b0;
    tick(3);
    reset_in = 1'b0;
    check({power_state_out, termination_resistance_out, receivers_on_out}, 8'h09);
    t_strength();
    t_read_train();
    t_pd(1'b0);
    t_pd(1'b1);
    t_sleep();
    give_verdict();
  end
  // Cuts a hang short well past the expected run of about three hundred cycles.
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule
